// >>> hw/sebl_loader.v
// serial eeprom boot loader: microwire master, boot load, software access
// assumes sw_* inputs come from logic on clk_sys; eeprom_do and strap from pins
// boot order: the strap settles through two flops, then a probe read sizes
// the part, then words 0 to 6 are read one frame each, chip select low between
// every frame bit is launched as sk rises and the returned bit is taken as
// sk falls, a whole sk half period after the part drove it, so do_s has settled
// software access is only taken once load_done is high and the link is idle
// a write is not followed by a busy poll: the caller must allow the part's
// own write time before the next access reaches it
// the eeprom data line is expected to idle high on a pull-up between frames
`timescale 1ns/1ps
`include "sebl_defs.vh"
module sebl_loader #(
	parameter BUS32 = 0
) (
	// clock and reset
	input  wire        clk_sys,
	input  wire        arst_n,
	// strap and microwire pins
	input  wire        eeprom_load_strap,
	output reg         eeprom_cs,
	output reg         eeprom_sk,
	output reg         eeprom_di,
	input  wire        eeprom_do,
	// software access (eeprom_sw_control_reg fields)
	input  wire        sw_req,
	input  wire        sw_write,
	input  wire [7:0]  sw_addr,
	input  wire [15:0] sw_wdata,
	output reg  [15:0] sw_rdata,
	output reg         sw_done,
	// loaded configuration
	output reg  [15:0] base_address,
	output reg  [47:0] host_mac_address,
	output reg  [15:0] boot_settings_word,
	output reg         clock_rate_low,
	output reg         async_bus_width_select,
	output reg         large_eeprom,
	output reg         load_done
);
	// link sequencer states: idle, shifting a frame, closing it, and the
	// chip select low gap that the part needs between two frames
	localparam S_IDLE  = 3'h0;
	localparam S_SHIFT = 3'h1;
	localparam S_WAIT  = 3'h2;
	localparam S_END   = 3'h3;
	localparam S_GAP   = 3'h4;
	// what the current frame is for
	localparam M_NONE  = 2'h0;
	localparam M_PROBE = 2'h1;
	localparam M_BOOT  = 2'h2;
	localparam M_SW    = 2'h3;

	// build a microwire frame: start bit, opcode, address, data, left aligned
	// a small part takes six address bits, a large one eight; the unused tail
	// is zero so the data line idles low after the last bit
	function [35:0] sebl_frame;
		input [1:0]  op;
		input [7:0]  adr;
		input [15:0] dat;
		input        big;
		begin
			if (big)
				sebl_frame = {1'b1, op, adr, dat, 9'h000};
			else
				sebl_frame = {1'b1, op, adr[5:0], dat, 11'h000};
		end
	endfunction

	// number of sk pulses of a frame: start bit, opcode, address, optional data
	function [5:0] sebl_bits;
		input [4:0] abits;
		input       with_data;
		begin
			if (with_data)
				sebl_bits = {1'b0, abits} + `SEBL_CMD_BITS + `SEBL_WORD_BITS;
			else
				sebl_bits = {1'b0, abits} + `SEBL_CMD_BITS;
		end
	endfunction

	// pin synchronisers
	reg  [1:0]  do_sync_reg;
	reg  [1:0]  strap_sync_reg;
	wire        do_s = do_sync_reg[1];
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			do_sync_reg    <= 2'h0;
			strap_sync_reg <= 2'h0;
		end else begin
			do_sync_reg    <= {do_sync_reg[0], eeprom_do};
			strap_sync_reg <= {strap_sync_reg[0], eeprom_load_strap};
		end
	end

	// the strap is read only once both synchroniser flops hold the pin, so
	// the boot decision never sees the reset value of the flops; this puts
	// the decision on the third edge after reset is released
	reg  [1:0]  wake_reg;
	wire        awake = (wake_reg == `SEBL_WAKE_EDGES);
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			wake_reg <= 2'h0;
		end else if (!awake) begin
			wake_reg <= wake_reg + 2'h1;
		end
	end

	// link sequencer, frame shifter, receive shifter and word pointer
	reg  [2:0]  state_reg;
	reg  [1:0]  mode_reg;
	reg  [35:0] sh_reg;
	reg  [5:0]  bits_reg;
	reg  [15:0] rx_reg;
	reg  [7:0]  word_reg;
	reg  [15:0] div_reg;
	reg         started_reg;
	reg         wr_reg;
	reg         ewen_reg;
	// probe result and address width of the detected part
	reg  [4:0]  rx_cnt_reg;
	reg  [4:0]  ab_reg;

	// state, shifting and result capture
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state_reg              <= S_IDLE;
			mode_reg               <= M_NONE;
			sh_reg                 <= 36'h0;
			bits_reg               <= 6'h0;
			rx_reg                 <= 16'h0;
			word_reg               <= 8'h00;
			div_reg                <= 16'h0;
			started_reg            <= 1'b0;
			wr_reg                 <= 1'b0;
			ewen_reg               <= 1'b0;
			rx_cnt_reg             <= 5'h0;
			ab_reg                 <= `SEBL_ABITS_SMALL;
			eeprom_cs              <= 1'b0;
			eeprom_sk              <= 1'b0;
			eeprom_di              <= 1'b0;
			sw_rdata               <= 16'h0;
			sw_done                <= 1'b0;
			// configuration outputs read zero until the load fills them
			base_address           <= 16'h0;
			host_mac_address       <= 48'h0;
			boot_settings_word     <= 16'h0;
			clock_rate_low         <= 1'b0;
			async_bus_width_select <= 1'b0;
			large_eeprom           <= 1'b0;
			load_done              <= 1'b0;
		end else begin
			sw_done <= 1'b0;
			case (state_reg)
			// idle: link parked, start the boot once, then serve software
			S_IDLE: begin
				eeprom_cs <= 1'b0;
				eeprom_sk <= 1'b0;
				if (!started_reg && awake) begin
					started_reg <= 1'b1;
					if (strap_sync_reg[1]) begin
						// probe with a large-part dummy read; a small part
						// returns data early, revealing fewer address bits
						mode_reg  <= M_PROBE;
						sh_reg    <= sebl_frame(`SEBL_OP_READ, `SEBL_PROBE_ADDR, 16'h0,
							1'b1);
						bits_reg  <= sebl_bits(`SEBL_ABITS_LARGE, 1'b1);
						eeprom_cs <= 1'b1;
						state_reg <= S_SHIFT;
					end else begin
						load_done <= 1'b1;
					end
				end else if (sw_req && load_done) begin
					mode_reg   <= M_SW;
					wr_reg     <= sw_write;
					ewen_reg   <= sw_write;
					eeprom_cs  <= 1'b1;
					state_reg  <= S_SHIFT;
					// a write is two frames: the enable frame first, then the word
					bits_reg   <= sebl_bits(ab_reg, !sw_write);
					if (sw_write)
						sh_reg <= sebl_frame(`SEBL_OP_EWEN, `SEBL_EWEN_ADDR >>
							(`SEBL_ABITS_LARGE - ab_reg), 16'h0, large_eeprom);
					else
						sh_reg <= sebl_frame(`SEBL_OP_READ, sw_addr, 16'h0,
							large_eeprom);
				end
			end
			// shifting: a bit is launched as sk rises, sk fall takes one in
			S_SHIFT: begin
				// clock divider makes eeprom_sk from clk_sys
				if (div_reg == `SEBL_HALF_CYC - 1) begin
					div_reg <= 16'h0;
					if (!eeprom_sk) begin
						eeprom_di <= sh_reg[35];
						sh_reg    <= {sh_reg[34:0], 1'b0};
						if (bits_reg == 6'h0)
							state_reg <= S_END;
						else
							eeprom_sk <= 1'b1;
					end else begin
						eeprom_sk <= 1'b0;
						bits_reg  <= bits_reg - 6'h1;
						rx_reg    <= {rx_reg[14:0], do_s}; // msb first
						// probe: note how many pulses were left when the dummy
						// zero came; a small part sends it two pulses earlier
						if (mode_reg == M_PROBE && !do_s && rx_cnt_reg == 5'h0 &&
							bits_reg <= `SEBL_PROBE_LAST)
							rx_cnt_reg <= 5'd1 + bits_reg[4:0];
					end
				end else begin
					div_reg <= div_reg + 16'h1;
				end
			end
			// end of frame: release the link and act on what came back
			S_END: begin
				eeprom_cs <= 1'b0;
				eeprom_di <= 1'b0;
				state_reg <= S_GAP;
				case (mode_reg)
				M_PROBE: begin
					// dummy zero seen after 6 address bits marks a small part
					if (rx_cnt_reg == `SEBL_SMALL_MARK) begin
						large_eeprom <= 1'b0;
						ab_reg       <= `SEBL_ABITS_SMALL;
					end else begin
						large_eeprom <= 1'b1;
						ab_reg       <= `SEBL_ABITS_LARGE;
					end
					mode_reg <= M_BOOT;
					word_reg <= 8'h00;
				end
				// boot frame: file words 0 to 3 and 6 in their outputs, the last ends the load
				M_BOOT: begin
					case (word_reg)
					`SEBL_W_BASE: base_address <= rx_reg;
					`SEBL_W_MAC0: host_mac_address[15:0]  <= rx_reg;
					`SEBL_W_MAC1: host_mac_address[31:16] <= rx_reg;
					`SEBL_W_MAC2: host_mac_address[47:32] <= rx_reg;
					`SEBL_W_CFG: begin
						// only the two low bits mean anything; the rest is kept
						boot_settings_word <= rx_reg;
						clock_rate_low <= rx_reg[`SEBL_CFG_CLK_BIT];
						async_bus_width_select <= (BUS32 != 0) ? 1'b0 :
							rx_reg[`SEBL_CFG_WID_BIT];
					end
					default: ;
					endcase
					if (word_reg == `SEBL_LAST_WORD) begin
						load_done <= 1'b1;
						mode_reg  <= M_NONE;
					end
					word_reg <= word_reg + 8'h01;
				end
				M_SW: begin
					if (ewen_reg) begin
						ewen_reg <= 1'b0;
					end else begin
						sw_rdata <= wr_reg ? sw_wdata : rx_reg;
						sw_done  <= 1'b1;
						mode_reg <= M_NONE;
					end
				end
				default: mode_reg <= M_NONE;
				endcase
			end
			// gap: chip select low, then the next boot word or the write frame
			S_GAP: begin
				// chip select low for one sk half period between frames
				if (div_reg == `SEBL_HALF_CYC - 1) begin
					div_reg <= 16'h0;
					if (mode_reg == M_BOOT) begin
						sh_reg    <= sebl_frame(`SEBL_OP_READ, word_reg, 16'h0,
							large_eeprom);
						bits_reg  <= sebl_bits(ab_reg, 1'b1);
						eeprom_cs <= 1'b1;
						state_reg <= S_SHIFT;
					end else if (mode_reg == M_SW) begin
						sh_reg    <= sebl_frame(`SEBL_OP_WRITE, sw_addr, sw_wdata,
							large_eeprom);
						bits_reg  <= sebl_bits(ab_reg, 1'b1);
						eeprom_cs <= 1'b1;
						state_reg <= S_SHIFT;
					end else begin
						state_reg <= S_IDLE;
					end
				end else begin
					div_reg <= div_reg + 16'h1;
				end
			end
			default: state_reg <= S_IDLE;
			endcase
		end
	end
endmodule

// >>> hw/sebl_defs.vh
// constants for the serial eeprom boot loader
// assumes a 250 MHz system clock and a microwire eeprom in 16-bit mode
`ifndef SEBL_DEFS_VH
`define SEBL_DEFS_VH
`define SEBL_CLK_MHZ       250
`define SEBL_SK_KHZ        1000
`define SEBL_HALF_CYC      ((`SEBL_CLK_MHZ * 1000) / (`SEBL_SK_KHZ * 2))
`define SEBL_LAST_WORD     8'h06
`define SEBL_W_BASE        8'h00
`define SEBL_W_MAC0        8'h01
`define SEBL_W_MAC1        8'h02
`define SEBL_W_MAC2        8'h03
`define SEBL_W_CFG         8'h06
`define SEBL_OP_READ       2'h2
`define SEBL_OP_WRITE      2'h1
`define SEBL_OP_EWEN       2'h0
`define SEBL_EWEN_ADDR     8'hC0
`define SEBL_ABITS_SMALL   5'h06
`define SEBL_ABITS_LARGE   5'h08
`define SEBL_CFG_CLK_BIT   1
`define SEBL_CFG_WID_BIT   0
`define SEBL_PROBE_ADDR    8'h00
`define SEBL_CMD_BITS      6'h03
`define SEBL_WORD_BITS     6'h10
`define SEBL_WAKE_EDGES    2'h2
`define SEBL_PROBE_LAST    6'h13
`define SEBL_SMALL_MARK    5'h14
`endif

// >>> verification/sebl_eeprom_model.sv
// microwire serial eeprom model with 16-bit words
// assumes cs active high; bits move on the rising edge of sk
`timescale 1ns/1ps
module sebl_eeprom_model #(
	parameter ABITS = 6
) (
	input wire cs,
	input wire sk,
	input wire di,
	output reg do_o = 1'b1
);
	reg [15:0] mem [0:255];
	reg [31:0] sh;
	reg [15:0] rd;
	reg        rd_on = 1'b0;
	integer    n = 0;
	// shift the command in, then the read word out msb first
	always @(posedge sk) begin
		sh = {sh[30:0], di};
		n = n + 1;
		if (rd_on) begin
			do_o <= rd[15];
			rd = rd << 1;
		end else if (n == 3 + ABITS && sh[ABITS+1:ABITS] == 2'h2) begin
			rd = mem[sh[ABITS-1:0]];
			rd_on = 1'b1;
			do_o <= 1'b0;
		end
	end
	// frame start clears the bit count
	always @(posedge cs)
		n = 0;
	// a whole write frame stores its word; released line floats high on its pull-up
	always @(negedge cs) begin
		if (n == 19 + ABITS && sh[ABITS+17:ABITS+16] == 2'h1)
			mem[sh[ABITS+15:16]] = sh[15:0];
		rd_on = 1'b0;
		do_o <= 1'b1;
	end
endmodule

// >>> verification/sebl_loader_properties.sv
// assertions on the boot loader ports
// bound to every sebl_loader instance
`timescale 1ns/1ps
module sebl_loader_properties #(
	parameter BUS32 = 0
) (
	input logic        clk_sys,
	input logic        arst_n,
	input logic        eeprom_cs,
	input logic        eeprom_sk,
	input logic        eeprom_di,
	input logic        sw_done,
	input logic [15:0] base_address,
	input logic [47:0] host_mac_address,
	input logic [15:0] boot_settings_word,
	input logic        clock_rate_low,
	input logic        async_bus_width_select,
	input logic        load_done
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	property p_rate; load_done |-> clock_rate_low == boot_settings_word[1]; endproperty
	a_rate: assert property (p_rate) else $error("clock rate differs from bit 1");
	property p_fast; !load_done |-> !clock_rate_low; endproperty
	a_fast: assert property (p_fast) else $error("low rate before load");
	property p_width;
		load_done |-> async_bus_width_select == (BUS32 ? 1'b0 : boot_settings_word[0]);
	endproperty
	a_width: assert property (p_width) else $error("bus width select wrong");
	property p_hold;
		load_done |=> load_done && $stable(base_address) && $stable(host_mac_address);
	endproperty
	a_hold: assert property (p_hold) else $error("loaded values moved");
	property p_sk_cs; eeprom_sk |-> eeprom_cs; endproperty
	a_sk_cs: assert property (p_sk_cs) else $error("sk outside frame");
	property p_di; eeprom_sk && $past(eeprom_sk) |-> $stable(eeprom_di); endproperty
	a_di: assert property (p_di) else $error("di moved while sk high");
	property p_sk_half; $rose(eeprom_sk) |=> eeprom_sk [*8]; endproperty
	a_sk_half: assert property (p_sk_half) else $error("sk high phase too short");
	property p_pulse; sw_done |=> !sw_done; endproperty
	a_pulse: assert property (p_pulse) else $error("done longer than a cycle");
	property p_gate; sw_done |-> load_done; endproperty
	a_gate: assert property (p_gate) else $error("access before load done");
endmodule

bind sebl_loader sebl_loader_properties #(.BUS32(BUS32)) i_sebl_loader_properties (
	.clk_sys, .arst_n, .eeprom_cs, .eeprom_sk, .eeprom_di, .sw_done, .base_address,
	.host_mac_address, .boot_settings_word, .clock_rate_low, .async_bus_width_select,
	.load_done);

// >>> verification/sebl_loader_tb_top.sv
// self-checking bench for the boot loader with a small eeprom model
// assumes the loader runs its serial clock at 1 MHz from clk_sys
`timescale 1ns/1ps
`define check_eq(a, e) begin cmp_count++; if ((a) !== (e)) begin n_fail++; \
	$display("Error t=%0t got %h exp %h", $time, a, e); end end
module sebl_loader_tb_top;
	reg         clk_sys = 1'b0;
	reg         arst_n = 1'b0;
	reg         strap = 1'b1;
	reg         sw_req = 1'b0;
	reg         sw_write = 1'b0;
	reg  [7:0]  sw_addr = 8'h00;
	reg  [15:0] sw_wdata = 16'h0000;
	wire        cs, sk, di, dout, done, ld, rlow, wid, big;
	wire [15:0] rdata, base, cfg;
	wire [47:0] mac;
	integer     n_fail = 0;
	integer     cmp_count = 0;
	integer     i;
	// 250 MHz system clock
	always #2 clk_sys = ~clk_sys;
	sebl_loader i_sebl_loader (.clk_sys(clk_sys), .arst_n(arst_n), .eeprom_load_strap(strap),
		.eeprom_cs(cs), .eeprom_sk(sk), .eeprom_di(di), .eeprom_do(dout), .sw_req(sw_req),
		.sw_write(sw_write), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_rdata(rdata),
		.sw_done(done), .base_address(base), .host_mac_address(mac),
		.boot_settings_word(cfg), .clock_rate_low(rlow), .async_bus_width_select(wid),
		.large_eeprom(big), .load_done(ld));
	sebl_eeprom_model i_sebl_eeprom_model (.cs(cs), .sk(sk), .di(di), .do_o(dout));
	// reset for 20 cycles with the given strap level, then wait for load
	task do_reset(input reg s);
		@(negedge clk_sys);
		arst_n = 1'b0;
		strap = s;
		repeat (20) @(negedge clk_sys);
		arst_n = 1'b1;
		for (i = 0; i < 70000 && !ld; i++) @(negedge clk_sys);
	endtask
	// one software access, request held until done is seen
	task sw_op(input reg w, input reg [7:0] a, input reg [15:0] d);
		sw_write = w;
		sw_addr = a;
		sw_wdata = d;
		sw_req = 1'b1;
		@(negedge clk_sys);
		for (i = 0; i < 30000 && !done; i++) @(negedge clk_sys);
		sw_req = 1'b0;
		`check_eq(done, 1'b1)
	endtask
	// boot from a small part, check the loaded fields except boot_settings_word
	task t_boot;
		i_sebl_eeprom_model.mem[0] = 16'h1234;
		i_sebl_eeprom_model.mem[1] = 16'hBBAA;
		i_sebl_eeprom_model.mem[2] = 16'hDDCC;
		i_sebl_eeprom_model.mem[3] = 16'hFFEE;
		i_sebl_eeprom_model.mem[4] = 16'h5555;
		i_sebl_eeprom_model.mem[5] = 16'hAAAA;
		i_sebl_eeprom_model.mem[6] = 16'hFFFE;
		do_reset(1'b1);
		`check_eq(ld, 1'b1)
		`check_eq(base, 16'h1234)
		`check_eq(mac, 48'hFFEEDDCCBBAA)
		`check_eq({rlow, wid}, 2'h2)
		`check_eq(big, 1'b0)
	endtask
	// software write then read back the same word
	task t_sw;
		sw_op(1'b1, 8'h15, 16'h5A3C);
		`check_eq(i_sebl_eeprom_model.mem[8'h15], 16'h5A3C)
		@(negedge clk_sys);
		sw_op(1'b0, 8'h15, 16'h0000);
		`check_eq(rdata, 16'h5A3C)
	endtask
	// strap low: ready at once, nothing loaded
	task t_strap_low;
		do_reset(1'b0);
		`check_eq({ld, cs, base, rlow}, 19'h40000)
	endtask
	// print counts and verdict, then stop
	task complete_run;
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// main sequence
	initial begin
		t_boot;
		t_sw;
		t_strap_low;
		complete_run;
	end
	// watchdog
	initial begin
		#600000;
		n_fail++;
		complete_run;
	end
endmodule
